// ---- src/clock_sync_pin_config.sv ----
// Clock dividers, sync generation and strap capture of the converter front end
`timescale 1ns/1ps
`include "cfg_consts.svh"
module clock_sync_pin_config
    import cfg_pkg::*;
#(
    parameter int LANE_BITS   = 64,
    parameter int INIT_CYCLES = `INIT_CYCLES
) (
    input  wire logic                   sys_clk,
    input  wire logic                   nrst,
    input  wire logic                   clock_sel_pin,
    input  wire logic                   start_n,
    input  wire logic                   sync_in_pin,
    input  wire logic                   sar_convert_pin,
    input  wire logic                   lane_format_bit0,
    input  wire logic                   lane_format_bit1,
    input  wire logic                   bitclk_div_sel0,
    input  wire logic                   bitclk_div_sel1,
    input  wire logic                   bitclk_div_sel2,
    input  wire logic                   strap_mode_bit0,
    input  wire logic                   strap_mode_bit1,
    input  wire logic                   strap_mode_bit2,
    input  wire logic                   strap_mode_bit3,
    input  wire logic                   spi_low_power,
    input  wire logic [1:0]             spi_lane_format,
    input  wire logic [2:0]             spi_bitclk_div,
    input  wire logic                   spi_sync_toggle,
    input  wire logic                   spi_clock_qualify_disable,
    input  wire logic                   lane_load,
    input  wire logic [4*LANE_BITS-1:0] lane_word,
    output logic                        internal_osc_select,
    output logic                        crystal_select,
    output logic                        cfg_ready,
    output logic                        modulator_clock,
    output logic                        output_bit_clock,
    output logic                        bit_tick,
    output logic [3:0]                  data_output_lane,
    output logic                        sync_out,
    output logic                        digital_reset,
    output logic                        spi_control_mode,
    output logic                        spi_readout,
    output logic                        ext_features_enable,
    output logic                        clock_qualify_disable,
    output logic                        low_power,
    output logic [10:0]                 decimation,
    output logic [11:0]                 output_data_rate_khz,
    output logic [5:0]                  max_odr_khz,
    output gain_code_t                  pga_gain_grp0,
    output gain_code_t                  pga_gain_grp1,
    output logic                        ref_internal,
    output logic [2:0]                  active_lanes
);
    initial begin
        if (LANE_BITS < 2 || INIT_CYCLES < 1 || INIT_CYCLES > 65535)
            $error("unsupported parameters");
    end

    localparam logic [15:0] INIT_LAST = 16'(INIT_CYCLES - 1);

    // Pin synchroniser: every pin is outside the clock domain
    logic [`PIN_COUNT-1:0] pin_meta_reg, pin_meta_next;
    logic [`PIN_COUNT-1:0] pin_sync_reg, pin_sync_next;
    logic                  start_prev_reg, start_prev_next;
    logic                  sync_prev_reg, sync_prev_next;
    logic                  toggle_prev_reg, toggle_prev_next;

    always_comb begin
        pin_meta_next    = {strap_mode_bit3, strap_mode_bit2, strap_mode_bit1, strap_mode_bit0,
                            bitclk_div_sel2, bitclk_div_sel1, bitclk_div_sel0,
                            lane_format_bit1, lane_format_bit0, sar_convert_pin,
                            sync_in_pin, start_n, clock_sel_pin};
        pin_sync_next    = pin_meta_reg;
        start_prev_next  = pin_sync_reg[`PIN_START_N];
        sync_prev_next   = pin_sync_reg[`PIN_SYNC_IN];
        toggle_prev_next = spi_sync_toggle;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            // Idle levels: start high, sync low
            pin_meta_reg    <= `PIN_COUNT'h2;
            pin_sync_reg    <= `PIN_COUNT'h2;
            start_prev_reg  <= 1'b1;
            sync_prev_reg   <= 1'b0;
            toggle_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg    <= pin_meta_next;
            pin_sync_reg    <= pin_sync_next;
            start_prev_reg  <= start_prev_next;
            sync_prev_reg   <= sync_prev_next;
            toggle_prev_reg <= toggle_prev_next;
        end
    end

    logic sync_edge;
    logic start_edge;
    logic toggle_edge;
    assign sync_edge   = pin_sync_reg[`PIN_SYNC_IN] && !sync_prev_reg;
    assign start_edge  = !pin_sync_reg[`PIN_START_N] && start_prev_reg;
    assign toggle_edge = spi_sync_toggle != toggle_prev_reg;

    // Boot sequence and strap latches
    boot_state_t state_reg, state_next;
    logic [15:0] init_cnt_reg, init_cnt_next;
    logic        clk_sel_reg, clk_sel_next;
    logic        sar_reg, sar_next;
    logic [1:0]  fmt_reg, fmt_next;
    logic [2:0]  bdiv_reg, bdiv_next;
    logic [3:0]  mode_reg, mode_next;
    logic        dreset_reg, dreset_next;
    logic        capture;

    always_comb begin
        state_next    = state_reg;
        init_cnt_next = init_cnt_reg;
        clk_sel_next  = clk_sel_reg;
        sar_next      = sar_reg;
        fmt_next      = fmt_reg;
        bdiv_next     = bdiv_reg;
        mode_next     = mode_reg;
        capture       = 1'b0;
        unique case (state_reg)
            ST_INIT: begin
                init_cnt_next = init_cnt_reg + 16'h1;
                // R4 leave oscillator after init
                if (init_cnt_reg == INIT_LAST) begin
                    state_next   = ST_RUN;
                    capture      = 1'b1;
                    clk_sel_next = pin_sync_reg[`PIN_CLOCK_SEL];
                end
            end
            ST_RUN: begin
                // R23 re-sample on sync
                capture = sync_edge;
            end
        endcase
        // R17 latch straps
        if (capture) begin
            sar_next  = pin_sync_reg[`PIN_SAR_CONVERT];
            fmt_next  = pin_sync_reg[`PIN_FMT_LSB +: 2];
            bdiv_next = pin_sync_reg[`PIN_BITCLK_LSB +: 3];
            mode_next = pin_sync_reg[`PIN_MODE_LSB +: 4];
        end
        // R7 filter reset only, settings kept
        dreset_next = (state_reg == ST_INIT) || (state_reg == ST_RUN && sync_edge);
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_reg    <= ST_INIT;
            init_cnt_reg <= 16'h0;
            clk_sel_reg  <= 1'b0;
            sar_reg      <= 1'b0;
            fmt_reg      <= 2'h0;
            bdiv_reg     <= 3'h0;
            mode_reg     <= 4'h0;
            dreset_reg   <= 1'b1;
        end else begin
            state_reg    <= state_next;
            init_cnt_reg <= init_cnt_next;
            clk_sel_reg  <= clk_sel_next;
            sar_reg      <= sar_next;
            fmt_reg      <= fmt_next;
            bdiv_reg     <= bdiv_next;
            mode_reg     <= mode_next;
            dreset_reg   <= dreset_next;
        end
    end

    // R4 oscillator until switch-over
    assign internal_osc_select = (state_reg == ST_INIT);
    // R5 one: crystal, zero: CMOS input
    assign crystal_select = clk_sel_reg;
    assign cfg_ready      = (state_reg == ST_RUN);
    assign digital_reset  = dreset_reg;

    // Mode pin lookup
    strap_if st ();
    assign st.mode = mode_reg;
    mode_pin_decoder u_decoder (
        .st (st.decoder)
    );

    // R20 code 11 gives serial control
    assign spi_control_mode = (fmt_reg == `FMT_SERIAL_CTRL);
    // R16 extended features only under serial control
    assign ext_features_enable = spi_control_mode;
    // R3 qualify disable honoured only under serial control
    assign clock_qualify_disable = spi_control_mode && spi_clock_qualify_disable;
    // R20 SAR high in strap control reads over serial port
    assign spi_readout = !spi_control_mode && sar_reg;

    logic [1:0] eff_fmt;
    logic [2:0] eff_bdiv;
    assign low_power = spi_control_mode ? spi_low_power : st.low_power;
    assign eff_fmt   = spi_control_mode ? spi_lane_format : fmt_reg;
    // R21 strap pins set bit clock in strap control
    assign eff_bdiv  = spi_control_mode ? spi_bitclk_div : bdiv_reg;

    // R18 gain per group of four, rate from decimation
    assign pga_gain_grp0        = st.gain_grp0;
    assign pga_gain_grp1        = st.gain_grp1;
    assign ref_internal         = st.ref_internal;
    assign decimation           = 11'(11'h1 << st.dec_log2);
    assign output_data_rate_khz = (low_power ? `ODR_BASE_LP_KHZ : `ODR_BASE_HR_KHZ) >> st.dec_log2;
    // R15 fixed notch at the maximum rate
    assign max_odr_khz          = low_power ? `MAX_ODR_LP_KHZ : `MAX_ODR_HR_KHZ;

    // R19 lane count by format code
    always_comb begin
        active_lanes = 3'h0;
        if (!spi_readout) begin
            unique case (eff_fmt)
                `FMT_FOUR_LANES:  active_lanes = 3'h4;
                `FMT_TWO_LANES:   active_lanes = 3'h2;
                `FMT_ONE_LANE:    active_lanes = 3'h1;
                `FMT_SERIAL_CTRL: active_lanes = 3'h0;
            endcase
        end
    end

    // Dividers restart on the filter reset so all phases line up after a sync
    logic [`BITCLK_CNT_W-1:0] div_cnt_reg, div_cnt_next;
    logic                     mod_clk_reg, mod_clk_next;
    logic                     bclk_reg, bclk_next;
    logic [`BITCLK_CNT_W-1:0] tick_mask;
    logic                     tick;

    assign tick_mask = `BITCLK_CNT_W'((8'h1 << eff_bdiv) - 8'h1);
    // R22 divide by two to the code
    assign tick      = (div_cnt_reg & tick_mask) == tick_mask;

    always_comb begin
        div_cnt_next = dreset_reg ? '0 : div_cnt_reg + `BITCLK_CNT_W'(1);
        // R2 divide by 4 or 8
        mod_clk_next = div_cnt_next[low_power ? `MOD_DIV_LP_BIT : `MOD_DIV_HR_BIT];
        // R6 bit clock level from master clock
        if (eff_bdiv == 3'h0)
            bclk_next = 1'b1;
        else
            bclk_next = div_cnt_next[eff_bdiv - 3'h1];
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            div_cnt_reg <= '0;
            mod_clk_reg <= 1'b0;
            bclk_reg    <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            mod_clk_reg <= mod_clk_next;
            bclk_reg    <= bclk_next;
        end
    end

    assign modulator_clock  = mod_clk_reg;
    assign output_bit_clock = bclk_reg;
    assign bit_tick         = tick && !dreset_reg;

    // R6 shift results out on bit ticks, MSB first
    logic [LANE_BITS-1:0] shift_reg [4];
    logic [LANE_BITS-1:0] shift_next [4];
    logic [3:0]           dout_reg, dout_next;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            shift_next[i] = shift_reg[i];
            if (lane_load)
                shift_next[i] = lane_word[i*LANE_BITS +: LANE_BITS];
            else if (bit_tick)
                shift_next[i] = {shift_reg[i][LANE_BITS-2:0], 1'b0};
            dout_next[i] = dout_reg[i];
            if (bit_tick)
                dout_next[i] = (3'(i) < active_lanes) && shift_reg[i][LANE_BITS-1];
            if (3'(i) >= active_lanes)
                dout_next[i] = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            for (int i = 0; i < 4; i++)
                shift_reg[i] <= '0;
            dout_reg <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++)
                shift_reg[i] <= shift_next[i];
            dout_reg <= dout_next;
        end
    end

    assign data_output_lane = dout_reg;

    // Sync output pulse generator; a request during a pulse restarts it
    logic [3:0] sync_cnt_reg, sync_cnt_next;
    logic       sync_req;

    // R10 resynchronised start pin
    // R11 control bit toggle under serial control
    assign sync_req = cfg_ready && (start_edge || (spi_control_mode && toggle_edge));

    always_comb begin
        sync_cnt_next = sync_cnt_reg;
        if (sync_req)
            sync_cnt_next = `SYNC_OUT_CYCLES;
        else if (sync_cnt_reg != 4'h0)
            sync_cnt_next = sync_cnt_reg - 4'h1;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst)
            sync_cnt_reg <= 4'h0;
        else
            sync_cnt_reg <= sync_cnt_next;
    end

    assign sync_out = (sync_cnt_reg != 4'h0);
endmodule

// ---- src/cfg_consts.svh ----
// Constants for the clock, sync and strap configuration front end
// Functional notes
// R1 - Host keeps master clock within mode limit
// R2 - Modulator clock is master divided 4/8
// R3 - Host sets qualify disable below 256 kHz
// R4 - Start on oscillator, then chosen clock
// R5 - Select pin picks CMOS or crystal source
// R6 - Bit clock from master clock shifts data
// R7 - Sync pulse resets filter, keeps settings
// R8 - Host syncs after filter setting changes
// R9 - Sync input pulse is master-clock synchronous
// R10 - Start pin resynchronised onto sync output
// R11 - Control bit toggle emits sync output pulse
// R12 - Board loops sync output to input
// R13 - Shared sync needs one common clock
// R14 - Unused start pin tied high
// R15 - Notch at max rate and selected rate
// R16 - Strap control disables extended features
// R17 - Mode pins set mode, decimation, gain, reference
// R18 - Gain per four channels; rate from decimation
// R19 - Format code picks four, two, one lanes
// R20 - Code 11 serial control; SAR high serial readout
// R21 - Select pins set bit clock submultiple
// R22 - Bit clock divide is two to code
// R23 - Every sync pulse re-samples all straps; code re-samples all but clock select, and only after init
// R24 - Host pulses reset at power-up
// R25 - Sixteen-entry mode pin lookup table
`ifndef CFG_CONSTS_SVH
`define CFG_CONSTS_SVH

`define INIT_CYCLES        16'h0010
`define SYNC_OUT_CYCLES    4'h4
`define MOD_DIV_HR_BIT     3'h1
`define MOD_DIV_LP_BIT     3'h2
`define BITCLK_CNT_W       7
`define ODR_BASE_HR_KHZ    12'h800
`define ODR_BASE_LP_KHZ    12'h200
`define MAX_ODR_HR_KHZ     6'h20
`define MAX_ODR_LP_KHZ     6'h08
`define FMT_FOUR_LANES     2'h0
`define FMT_TWO_LANES      2'h1
`define FMT_ONE_LANE       2'h2
`define FMT_SERIAL_CTRL    2'h3
`define DEC_LOG2_1024      4'ha
`define DEC_LOG2_512       4'h9
`define DEC_LOG2_256       4'h8
`define DEC_LOG2_128       4'h7
`define DEC_LOG2_64        4'h6
`define PIN_CLOCK_SEL      0
`define PIN_START_N        1
`define PIN_SYNC_IN        2
`define PIN_SAR_CONVERT    3
`define PIN_FMT_LSB        4
`define PIN_BITCLK_LSB     6
`define PIN_MODE_LSB       9
`define PIN_COUNT          13

`endif

// ---- src/cfg_pkg.sv ----
// Types shared by the configuration front end
package cfg_pkg;
    typedef enum logic [1:0] {
        GAIN_X1 = 2'h0,
        GAIN_X2 = 2'h1,
        GAIN_X4 = 2'h2,
        GAIN_X8 = 2'h3
    } gain_code_t;

    typedef enum logic [0:0] {
        ST_INIT = 1'h0,
        ST_RUN  = 1'h1
    } boot_state_t;
endpackage

// ---- src/strap_if.sv ----
// Carrier between the main block and the mode pin decoder
`timescale 1ns/1ps
interface strap_if;
    import cfg_pkg::*;
    logic [3:0]  mode;
    logic [3:0]  dec_log2;
    logic        low_power;
    gain_code_t  gain_grp0;
    gain_code_t  gain_grp1;
    logic        ref_internal;

    modport decoder (input mode, output dec_log2, output low_power,
                     output gain_grp0, output gain_grp1, output ref_internal);
    modport user (output mode, input dec_log2, input low_power,
                  input gain_grp0, input gain_grp1, input ref_internal);
endinterface

// ---- src/mode_pin_decoder.sv ----
// Fixed lookup of the four latched mode pins
`timescale 1ns/1ps
`include "cfg_consts.svh"
module mode_pin_decoder
    import cfg_pkg::*;
(
    strap_if.decoder st
);
    // R25 sixteen-entry lookup
    // R17 mode, decimation, gain, reference
    always_comb begin
        st.dec_log2     = `DEC_LOG2_1024;
        st.low_power    = 1'b0;
        st.gain_grp0    = GAIN_X1;
        st.gain_grp1    = GAIN_X1;
        st.ref_internal = 1'b0;
        unique case (st.mode)
            4'h0: st.dec_log2 = `DEC_LOG2_1024;
            4'h1: st.dec_log2 = `DEC_LOG2_512;
            4'h2: st.dec_log2 = `DEC_LOG2_256;
            4'h3: st.dec_log2 = `DEC_LOG2_128;
            4'h4: st.dec_log2 = `DEC_LOG2_64;
            4'h5: begin
                st.dec_log2  = `DEC_LOG2_512;
                st.gain_grp1 = GAIN_X4;
            end
            4'h6: begin
                st.dec_log2  = `DEC_LOG2_256;
                st.gain_grp1 = GAIN_X4;
            end
            4'h7: begin
                st.dec_log2  = `DEC_LOG2_128;
                st.gain_grp1 = GAIN_X4;
            end
            4'h8: begin
                st.dec_log2  = `DEC_LOG2_64;
                st.gain_grp1 = GAIN_X4;
            end
            4'h9: begin
                st.dec_log2     = `DEC_LOG2_512;
                st.ref_internal = 1'b1;
            end
            4'ha: begin
                st.dec_log2     = `DEC_LOG2_256;
                st.ref_internal = 1'b1;
            end
            4'hb: begin
                st.dec_log2     = `DEC_LOG2_128;
                st.ref_internal = 1'b1;
            end
            4'hc: begin
                st.dec_log2  = `DEC_LOG2_512;
                st.low_power = 1'b1;
            end
            4'hd: begin
                st.dec_log2  = `DEC_LOG2_256;
                st.low_power = 1'b1;
            end
            4'he: begin
                st.dec_log2  = `DEC_LOG2_128;
                st.low_power = 1'b1;
            end
            4'hf: begin
                st.dec_log2  = `DEC_LOG2_64;
                st.low_power = 1'b1;
            end
        endcase
    end
endmodule

// ---- tb/cfg_props.sv ----
// Checker for the clock, sync and strap front end
`timescale 1ns/1ps
module cfg_props #(
    parameter int INIT_CYCLES = 16
) (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic start_n,
    input  wire logic sync_in_pin,
    input  wire logic internal_osc_select,
    input  wire logic cfg_ready,
    input  wire logic modulator_clock,
    input  wire logic digital_reset,
    input  wire logic sync_out,
    input  wire logic spi_control_mode,
    input  wire logic ext_features_enable,
    input  wire logic clock_qualify_disable,
    input  wire logic low_power
);
    localparam int INIT_HI = INIT_CYCLES + 3;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_osc_then_ext: assert property (
        $rose(nrst) |-> (internal_osc_select && !cfg_ready)[*2] ##[1:INIT_HI] (cfg_ready && !internal_osc_select))
        else $error("boot order");
    a_mod_div_hr: assert property (
        $rose(modulator_clock) && !low_power && !digital_reset ##1 (!low_power && !digital_reset)[*4]
        |-> $rose(modulator_clock)) else $error("mod div 4");
    a_mod_div_lp: assert property (
        $rose(modulator_clock) && low_power && !digital_reset ##1 (low_power && !digital_reset)[*8]
        |-> $rose(modulator_clock)) else $error("mod div 8");
    a_sync_in_reset: assert property (
        $rose(sync_in_pin) && cfg_ready |-> ##[1:5] digital_reset) else $error("no sync reset");
    a_reset_one_cycle: assert property (
        $rose(digital_reset) && cfg_ready |=> !digital_reset) else $error("reset width");
    a_sync_out_width: assert property (
        $rose(sync_out) |-> sync_out[*4] ##1 !sync_out) else $error("sync width");
    a_start_to_sync: assert property (
        $fell(start_n) && cfg_ready |-> ##[1:5] $rose(sync_out)) else $error("no start sync");
    a_ext_serial_only: assert property (
        ext_features_enable == spi_control_mode) else $error("ext features");
    a_qual_serial_only: assert property (
        clock_qualify_disable |-> spi_control_mode) else $error("qualify disable");

    c_sync_reset: cover property ($rose(sync_in_pin) && cfg_ready ##[1:5] digital_reset);
    c_start_sync: cover property ($fell(start_n) && cfg_ready ##[1:5] $rose(sync_out));
    c_low_power: cover property ($rose(modulator_clock) && low_power);
endmodule

bind clock_sync_pin_config cfg_props #(.INIT_CYCLES(INIT_CYCLES)) u_props (
    .sys_clk, .nrst, .start_n, .sync_in_pin, .internal_osc_select, .cfg_ready, .modulator_clock,
    .digital_reset, .sync_out, .spi_control_mode, .ext_features_enable, .clock_qualify_disable, .low_power
);

// ---- tb/host_sync_model.sv ----
// Host-side model: sync source and asynchronous start request
`timescale 1ns/1ps
module host_sync_model (
    input  wire logic sys_clk,
    input  wire logic loop_en,
    input  wire logic sync_req,
    input  wire logic start_req,
    input  wire logic sync_out,
    output logic      sync_in_pin,
    output logic      start_n
);
    assign sync_in_pin = loop_en ? sync_out : sync_req;
    initial start_n = 1'b1;
    always @(posedge sys_clk) begin
        start_n <= #3 !start_req;
    end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the clock, sync and strap front end
`timescale 1ns/1ps
module tb_top
    import cfg_pkg::*;
;
    localparam logic [63:0] DL = 64'h6789_7896_7896_789a;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        clock_sel_pin = 1'b1;
    logic        sar = 1'b0;
    logic [1:0]  fmt = 2'h0;
    logic [2:0]  div = 3'h1;
    logic [3:0]  mode = 4'h0;
    logic        spi_low_power = 1'b1;
    logic [1:0]  spi_lane_format = 2'h0;
    logic [2:0]  spi_bitclk_div = 3'h1;
    logic        spi_sync_toggle = 1'b0;
    logic        spi_clock_qualify_disable = 1'b1;
    logic        lane_load = 1'b0;
    logic [31:0] lane_word = 32'h81f03ca5;
    logic        loop_en = 1'b0;
    logic        sync_req = 1'b0;
    logic        start_req = 1'b0;
    logic        start_n, sync_in_pin, internal_osc_select, crystal_select, cfg_ready, modulator_clock;
    logic        bit_tick, sync_out, digital_reset, spi_control_mode, spi_readout, ext_features_enable;
    logic        clock_qualify_disable, low_power, ref_internal, output_bit_clock;
    logic [3:0]  data_output_lane;
    logic [10:0] decimation;
    logic [11:0] output_data_rate_khz;
    logic [5:0]  max_odr_khz;
    logic [2:0]  active_lanes;
    logic [5:0]  obs;
    gain_code_t  pga_gain_grp0, pga_gain_grp1;
    int          fails = 0;
    int          n_tests = 0;

    always #5 sys_clk = ~sys_clk;
    assign obs = {output_bit_clock, modulator_clock, cfg_ready, digital_reset, sync_out, bit_tick};

    host_sync_model u_host (.sys_clk, .loop_en, .sync_req, .start_req, .sync_out, .sync_in_pin, .start_n);

    clock_sync_pin_config #(.LANE_BITS(8), .INIT_CYCLES(8)) u_dut (
        .sys_clk, .nrst, .clock_sel_pin, .start_n, .sync_in_pin, .sar_convert_pin(sar),
        .lane_format_bit0(fmt[0]), .lane_format_bit1(fmt[1]),
        .bitclk_div_sel0(div[0]), .bitclk_div_sel1(div[1]), .bitclk_div_sel2(div[2]),
        .strap_mode_bit0(mode[0]), .strap_mode_bit1(mode[1]), .strap_mode_bit2(mode[2]), .strap_mode_bit3(mode[3]),
        .spi_low_power, .spi_lane_format, .spi_bitclk_div, .spi_sync_toggle, .spi_clock_qualify_disable,
        .lane_load, .lane_word, .internal_osc_select, .crystal_select, .cfg_ready, .modulator_clock,
        .output_bit_clock, .bit_tick, .data_output_lane, .sync_out, .digital_reset, .spi_control_mode,
        .spi_readout, .ext_features_enable, .clock_qualify_disable, .low_power, .decimation,
        .output_data_rate_khz, .max_odr_khz, .pga_gain_grp0, .pga_gain_grp1, .ref_internal, .active_lanes
    );

    task automatic end_sim;
        $display("checks %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_hi(input int s);
        int k = 0;
        while (obs[s] !== 1'b1) begin
            if (k++ > 400) begin
                chk("wait", 12'h1, 12'h0);
                end_sim;
            end
            @(posedge sys_clk);
            #1;
        end
    endtask

    task automatic do_reset(input logic xtal);
        @(posedge sys_clk);
        nrst <= 1'b0;
        clock_sel_pin <= xtal;
        repeat (20) @(posedge sys_clk);
        #1;
        chk("osc", 12'h1, internal_osc_select);
        chk("ready", 12'h0, cfg_ready);
        @(posedge sys_clk);
        nrst <= 1'b1;
        wait_hi(3);
        chk("osc", 12'h0, internal_osc_select);
        chk("xtal", {11'h0, xtal}, crystal_select);
    endtask

    task automatic set_cfg(input logic s, input logic [1:0] f, input logic [2:0] d, input logic [3:0] m);
        @(posedge sys_clk);
        {sar, fmt, div, mode} <= {s, f, d, m};
        repeat (4) @(posedge sys_clk);
        sync_req <= 1'b1;
        @(posedge sys_clk);
        sync_req <= 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask

    task automatic period(input int s, output int n);
        logic prev;
        for (int e = 0; e < 2; e++) begin
            n = 0;
            do begin
                prev = obs[s];
                @(posedge sys_clk);
                #1;
                n++;
            end while (!(obs[s] === 1'b1 && (s == 0 || prev === 1'b0)) && n < 300);
        end
    endtask

    task automatic shift_out(input logic [31:0] exp);
        logic [31:0] got;
        @(posedge sys_clk);
        lane_load <= 1'b1;
        @(posedge sys_clk);
        lane_load <= 1'b0;
        #1;
        for (int b = 7; b >= 0; b--) begin
            wait_hi(0);
            @(posedge sys_clk);
            #1;
            for (int l = 0; l < 4; l++) got[l*8+b] = data_output_lane[l];
        end
        for (int l = 0; l < 4; l++) chk("lane", {4'h0, exp[l*8+:8]}, {4'h0, got[l*8+:8]});
    endtask

    initial begin
        logic lp;
        logic hit;
        int   n;
        do_reset(1'b1);
        for (int m = 0; m < 16; m++) begin
            set_cfg(1'b0, 2'h0, 3'h1, m[3:0]);
            lp = (m >= 12);
            chk("dec", 12'h1 << DL[m*4+:4], {1'b0, decimation});
            chk("lp", {11'h0, lp}, low_power);
            chk("odr", (lp ? 12'h200 : 12'h800) >> DL[m*4+:4], output_data_rate_khz);
            chk("notch", lp ? 12'h8 : 12'h20, {6'h0, max_odr_khz});
            chk("g0", GAIN_X1, pga_gain_grp0);
            chk("g1", (m >= 5 && m <= 8) ? GAIN_X4 : GAIN_X1, pga_gain_grp1);
            chk("ref", m >= 9 && m <= 11, ref_internal);
            period(4, n);
            chk("mclk", lp ? 12'h8 : 12'h4, 12'(n));
        end
        for (int s = 0; s < 2; s++) begin
            for (int f = 0; f < 4; f++) begin
                set_cfg(s[0], f[1:0], 3'h1, 4'h0);
                chk("serial", f == 3, spi_control_mode);
                chk("ext", f == 3, ext_features_enable);
                chk("qual", f == 3, clock_qualify_disable);
                if (f < 3) chk("readout", 12'(s), spi_readout);
                if (f < 3 && s == 0) chk("lanes", 12'h4 >> f, active_lanes);
            end
        end
        for (int c = 0; c < 8; c++) begin
            set_cfg(1'b0, 2'h0, c[2:0], 4'h0);
            period(0, n);
            chk("bitclk", 12'h1 << c, 12'(n));
            if (c > 0) begin
                period(5, n);
                chk("bclk", 12'h1 << c, 12'(n));
            end
        end
        set_cfg(1'b0, 2'h0, 3'h1, 4'h0);
        shift_out(lane_word);
        set_cfg(1'b0, 2'h2, 3'h1, 4'h0);
        shift_out(lane_word & 32'h000000ff);
        set_cfg(1'b0, 2'h0, 3'h1, 4'h0);
        hit = 1'b0;
        @(posedge sys_clk);
        spi_sync_toggle <= ~spi_sync_toggle;
        repeat (10) begin @(posedge sys_clk); #1; hit |= sync_out; end
        chk("toggle_pin", 12'h0, hit);
        set_cfg(1'b0, 2'h3, 3'h1, 4'h0);
        @(posedge sys_clk);
        spi_sync_toggle <= ~spi_sync_toggle;
        wait_hi(1);
        chk("toggle", 12'h1, sync_out);
        set_cfg(1'b0, 2'h0, 3'h1, 4'h0);
        @(posedge sys_clk);
        mode <= 4'hc;
        repeat (6) @(posedge sys_clk);
        #1;
        chk("hold", 12'h0, low_power);
        @(posedge sys_clk);
        loop_en <= 1'b1;
        start_req <= 1'b1;
        repeat (2) @(posedge sys_clk);
        start_req <= 1'b0;
        wait_hi(1);
        chk("start", 12'h1, sync_out);
        wait_hi(2);
        chk("loop", 12'h1, digital_reset);
        repeat (8) @(posedge sys_clk);
        loop_en <= 1'b0;
        #1;
        chk("relatch", 12'h1, low_power);
        do_reset(1'b0);
        end_sim;
    end
endmodule
